/* common/mis_pkg.sv */
// Notes on behaviour
// - source change waits until drive stopped
// - closed: keypad commands; open: terminal commands
// - terminals 5,4,3 pick preset; 6 picks jog
// - remote mode: analog input replaces preset 1
// - block while running: coast after 20ms, search
// - block while stopped: zero reference, stay stopped
// - block active: keypad shows blinking indication
// - normally-closed block input active when open
// - search input: block min time, then search
// - search starts at maximum or new setpoint
// - overcurrent: 2.0s decel; below level: resume
// - search current level 110% default, 0-200%
// - power loss: output off for min block
// - long loss: search at once on recovery
// - search V/f scaled by search ratio setting
// - timer output follows on/off delays
// - sample after 0.1s closed, freeze on open
// - hold input freezes ramp; release resumes ramp
// - stop during hold cancels hold, stops normally
package mis_pkg;

  typedef struct packed {
    logic       local_sel;
    logic [3:0] preset_sel;
    logic       block_no;
    logic       block_nc;
    logic       search_max;
    logic       search_set;
    logic       timer_in;
    logic       sample_hold;
    logic       hold;
    logic       fwd_run;
    logic       rev_run;
    logic       key_fwd;
    logic       key_rev;
  } mis_contacts_s;

  typedef enum logic [1:0] {MD_STOP, MD_RUN, MD_BLOCK, MD_SEARCH} mis_mode_e;

  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_FMAX       = 8'h04;
  localparam logic [7:0] OFS_ACCEL_STEP = 8'h08;
  localparam logic [7:0] OFS_SRCH_CUR   = 8'h0c;
  localparam logic [7:0] OFS_MIN_BLOCK  = 8'h10;
  localparam logic [7:0] OFS_SRCH_VF    = 8'h14;
  localparam logic [7:0] OFS_ON_DELAY   = 8'h18;
  localparam logic [7:0] OFS_OFF_DELAY  = 8'h1c;
  localparam logic [7:0] OFS_PRESET0    = 8'h20;
  localparam logic [7:0] OFS_STATUS     = 8'h40;
  localparam logic [7:0] OFS_OUT_FREQ   = 8'h44;
  localparam int         NUM_PRESETS    = 7;

  localparam int CTRL_NC_EN = 0;
  localparam int CTRL_SH_EN = 1;

  localparam logic [1:0]  RST_CTRL       = 2'h0;
  localparam logic [15:0] RST_FMAX       = 16'h0258;
  localparam logic [15:0] RST_ACCEL_STEP = 16'h0001;
  localparam logic [7:0]  RST_SRCH_CUR   = 8'h6e;
  localparam logic [7:0]  MAX_SRCH_CUR   = 8'hc8;
  localparam logic [7:0]  RST_MIN_BLOCK  = 8'h05;
  localparam logic [7:0]  RST_SRCH_VF    = 8'h64;
  localparam logic [7:0]  MAX_SRCH_VF    = 8'h64;
  localparam logic [7:0]  NORMAL_VF      = 8'h64;
  localparam logic [7:0]  RST_DELAY      = 8'h00;
  localparam logic [15:0] RST_JOG        = 16'h003c;
  localparam logic [15:0] RST_PRESET     = 16'h0000;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;

  localparam int BLOCK_DELAY_MS = 20;
  localparam int SAMPLE_MS      = 100;
  localparam int SETTING_STEP_MS = 100;
  localparam int SEARCH_DECEL_MS = 2000;
  localparam int BLINK_MS       = 500;

  localparam logic [7:0]  BLOCK_DELAY_TICKS  = 8'(BLOCK_DELAY_MS / TICK_MS);
  localparam logic [7:0]  SAMPLE_TICKS       = 8'(SAMPLE_MS / TICK_MS);
  localparam logic [15:0] SETTING_STEP_TICKS = 16'(SETTING_STEP_MS / TICK_MS);
  localparam logic [16:0] SEARCH_DECEL_TICKS = 17'(SEARCH_DECEL_MS / TICK_MS);
  localparam logic [9:0]  BLINK_TICKS        = 10'(BLINK_MS / TICK_MS);

endpackage

/* rtl/mis_top.sv */
`timescale 1ns/1ps
module mis_top #(
  parameter int unsigned TICK_CYCLES = mis_pkg::TICK_CYCLES
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire mis_pkg::mis_contacts_s i_contacts,
  input  wire logic [15:0]            i_analog_ref,
  input  wire logic [7:0]             i_out_current,
  input  wire logic                   i_power_loss,
  output logic                        o_gate_enable,
  output logic [15:0]                 o_freq_ref,
  output logic [15:0]                 o_out_freq,
  output logic [7:0]                  o_vf_scale,
  output logic                        o_timer_out,
  output logic                        o_block_blink,
  output logic                        o_local_active,
  output logic                        o_searching
);
  import mis_pkg::*;

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  function automatic logic preset_hit(input logic [7:0] addr);
    return addr >= OFS_PRESET0 && addr < OFS_PRESET0 + 8'(4 * NUM_PRESETS) && addr[1:0] == 2'h0;
  endfunction

  function automatic logic [2:0] preset_idx(input logic [7:0] addr);
    logic [7:0] d;
    d = addr - OFS_PRESET0;
    return d[4:2];
  endfunction

  logic [1:0]  ctrl;
  logic [15:0] fmax;
  logic [15:0] accel_step;
  logic [7:0]  search_current_level;
  logic [7:0]  min_block_time;
  logic [7:0]  search_vf_ratio;
  logic [7:0]  on_delay_setting;
  logic [7:0]  off_delay_setting;
  logic [15:0] preset [NUM_PRESETS];

  mis_mode_e   mode;
  mis_mode_e   next_mode;
  logic [TW-1:0] tick_cnt;
  logic        tick;
  logic        local_mode;
  logic        run_cmd;
  logic        ext_blk;
  logic        ext_blk_eff;
  logic [7:0]  blk_cnt;
  logic        force_zero;
  logic        prev_max;
  logic        prev_set;
  logic        srch_edge;
  logic        srch_from_max;
  logic [15:0] mb_cnt;
  logic [15:0] mb_limit;
  logic        mb_done;
  logic [7:0]  sh_cnt;
  logic [15:0] sh_value;
  logic [15:0] analog_ref;
  logic [15:0] next_freq_ref;
  logic [16:0] srch_frac;
  logic        srch_dec;
  logic [15:0] tmr_cnt;
  logic [15:0] tmr_limit;
  logic [9:0]  blink_cnt;
  logic        blink_phase;
  logic        hold_eff;
  logic [15:0] ramp_target;

  // apb slave: one wait state, pready held one cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && penable && !pready) begin
        if (preset_hit(paddr)) begin
          prdata <= {16'h0, preset[preset_idx(paddr)]};
        end else begin
          unique case (paddr)
            OFS_CTRL:       prdata <= {30'h0, ctrl};
            OFS_FMAX:       prdata <= {16'h0, fmax};
            OFS_ACCEL_STEP: prdata <= {16'h0, accel_step};
            OFS_SRCH_CUR:   prdata <= {24'h0, search_current_level};
            OFS_MIN_BLOCK:  prdata <= {24'h0, min_block_time};
            OFS_SRCH_VF:    prdata <= {24'h0, search_vf_ratio};
            OFS_ON_DELAY:   prdata <= {24'h0, on_delay_setting};
            OFS_OFF_DELAY:  prdata <= {24'h0, off_delay_setting};
            OFS_STATUS:     prdata <= {24'h0, ext_blk, force_zero, o_timer_out, o_searching,
                                       o_gate_enable, local_mode, mode};
            OFS_OUT_FREQ:   prdata <= {16'h0, o_out_freq};
            default:        pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // writes land on the edge where pready is sampled high
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl                 <= RST_CTRL;
      fmax                 <= RST_FMAX;
      accel_step           <= RST_ACCEL_STEP;
      search_current_level <= RST_SRCH_CUR;
      min_block_time       <= RST_MIN_BLOCK;
      search_vf_ratio      <= RST_SRCH_VF;
      on_delay_setting     <= RST_DELAY;
      off_delay_setting    <= RST_DELAY;
      for (int i = 0; i < NUM_PRESETS - 1; i++) begin
        preset[i] <= RST_PRESET;
      end
      preset[NUM_PRESETS-1] <= RST_JOG;
    end else if (psel && penable && pready && pwrite) begin
      if (preset_hit(paddr)) begin
        preset[preset_idx(paddr)] <= pwdata[15:0];
      end else begin
        unique case (paddr)
          OFS_CTRL:       ctrl <= pwdata[1:0];
          OFS_FMAX:       fmax <= pwdata[15:0];
          OFS_ACCEL_STEP: accel_step <= pwdata[15:0];
          // out-of-range search current and V/f ratio clamp rather than wrap
          OFS_SRCH_CUR:   search_current_level <= (pwdata[31:0] > 32'(MAX_SRCH_CUR)) ? MAX_SRCH_CUR
                                                  : pwdata[7:0];
          OFS_MIN_BLOCK:  min_block_time <= pwdata[7:0];
          OFS_SRCH_VF:    search_vf_ratio <= (pwdata[31:0] > 32'(MAX_SRCH_VF)) ? MAX_SRCH_VF
                                             : pwdata[7:0];
          OFS_ON_DELAY:   on_delay_setting <= pwdata[7:0];
          OFS_OFF_DELAY:  off_delay_setting <= pwdata[7:0];
          default:        ;
        endcase
      end
    end
  end

  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // source switch only takes effect from standstill
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      local_mode <= 1'b0;
    end else if (mode == MD_STOP) begin
      local_mode <= i_contacts.local_sel;
    end
  end

  assign run_cmd = local_mode ? (i_contacts.key_fwd || i_contacts.key_rev)
                              : (i_contacts.fwd_run || i_contacts.rev_run);

  assign ext_blk = i_contacts.block_no || (ctrl[CTRL_NC_EN] && !i_contacts.block_nc);
  assign ext_blk_eff = ext_blk && (blk_cnt == BLOCK_DELAY_TICKS);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      blk_cnt <= 8'h0;
    end else if (!ext_blk) begin
      blk_cnt <= 8'h0;
    end else if (tick && blk_cnt != BLOCK_DELAY_TICKS) begin
      blk_cnt <= blk_cnt + 8'h1;
    end
  end

  // zero reference latched by a block at standstill, lifted by a new run
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      force_zero <= 1'b0;
    end else if (ext_blk_eff && !run_cmd) begin
      force_zero <= 1'b1;
    end else if (run_cmd) begin
      force_zero <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_max      <= 1'b0;
      prev_set      <= 1'b0;
      srch_from_max <= 1'b0;
    end else begin
      prev_max <= i_contacts.search_max;
      prev_set <= i_contacts.search_set;
      if (mode != MD_BLOCK && next_mode == MD_BLOCK) begin
        srch_from_max <= srch_edge && i_contacts.search_max;
      end
    end
  end

  // momentary closure is enough, so the edge is what counts
  assign srch_edge = (i_contacts.search_max && !prev_max) || (i_contacts.search_set && !prev_set);

  assign mb_limit = 16'(min_block_time) * SETTING_STEP_TICKS;
  assign mb_done  = mb_cnt >= mb_limit;

  // counts from block entry, so a loss longer than the limit ends it at once
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mb_cnt <= 16'h0;
    end else if (mode != MD_BLOCK) begin
      mb_cnt <= 16'h0;
    end else if (tick && !mb_done) begin
      mb_cnt <= mb_cnt + 16'h1;
    end
  end

  always_comb begin
    next_mode = mode;
    unique case (mode)
      MD_STOP: begin
        if (run_cmd && !ext_blk_eff && !i_power_loss) begin
          next_mode = MD_RUN;
        end
      end
      MD_RUN, MD_SEARCH: begin
        if (ext_blk_eff || i_power_loss || srch_edge) begin
          next_mode = MD_BLOCK;
        end else if (mode == MD_RUN && !run_cmd && o_out_freq == 16'h0) begin
          next_mode = MD_STOP;
        end else if (mode == MD_SEARCH && (i_out_current < search_current_level || !run_cmd)) begin
          next_mode = MD_RUN;
        end
      end
      MD_BLOCK: begin
        if (!ext_blk_eff && !i_power_loss && mb_done) begin
          next_mode = run_cmd ? MD_SEARCH : MD_STOP;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode <= MD_STOP;
    end else begin
      mode <= next_mode;
    end
  end

  // sample/hold: track after 0.1 s closed, freeze on opening
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_cnt   <= 8'h0;
      sh_value <= 16'h0;
    end else begin
      if (!i_contacts.sample_hold) begin
        sh_cnt <= 8'h0;
      end else if (tick && sh_cnt <= SAMPLE_TICKS) begin
        sh_cnt <= sh_cnt + 8'h1;
      end
      if (i_contacts.sample_hold && sh_cnt > SAMPLE_TICKS) begin
        sh_value <= i_analog_ref;
      end
    end
  end

  assign analog_ref = ctrl[CTRL_SH_EN] ? sh_value : i_analog_ref;

  // codes 110 and 111 are undefined; they reuse preset 6
  always_comb begin
    next_freq_ref = 16'h0;
    if (force_zero) begin
      next_freq_ref = 16'h0;
    end else if (i_contacts.preset_sel[3]) begin
      next_freq_ref = preset[NUM_PRESETS-1];
    end else if (i_contacts.preset_sel[2:0] == 3'h0 && !local_mode) begin
      next_freq_ref = analog_ref;
    end else if (i_contacts.preset_sel[2:0] > 3'h5) begin
      next_freq_ref = preset[5];
    end else begin
      next_freq_ref = preset[i_contacts.preset_sel[2:0]];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_freq_ref <= 16'h0;
    end else begin
      o_freq_ref <= next_freq_ref;
    end
  end

  // hold is ignored without a run, so a stop ramps down normally
  assign hold_eff    = i_contacts.hold && run_cmd;
  assign ramp_target = run_cmd ? o_freq_ref : 16'h0;
  assign srch_dec    = srch_frac >= SEARCH_DECEL_TICKS && o_out_freq != 16'h0;

  // fractional accumulator spreads a full-scale drop over 2.0 s
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      srch_frac <= 17'h0;
    end else if (mode != MD_SEARCH) begin
      srch_frac <= 17'h0;
    end else begin
      srch_frac <= srch_frac + (tick ? {1'b0, fmax} : 17'h0)
                 - (srch_dec ? SEARCH_DECEL_TICKS : 17'h0);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_freq <= 16'h0;
    end else if (next_mode == MD_STOP) begin
      o_out_freq <= 16'h0;
    end else if (mode == MD_BLOCK && next_mode == MD_SEARCH) begin
      o_out_freq <= srch_from_max ? fmax : o_freq_ref;
    end else if (mode == MD_SEARCH && next_mode == MD_SEARCH) begin
      if (srch_dec) begin
        o_out_freq <= o_out_freq - 16'h1;
      end
    end else if (mode == MD_RUN && next_mode == MD_RUN && tick && !hold_eff) begin
      if (o_out_freq < ramp_target) begin
        o_out_freq <= (ramp_target - o_out_freq > accel_step) ? o_out_freq + accel_step : ramp_target;
      end else if (o_out_freq > ramp_target) begin
        o_out_freq <= (o_out_freq - ramp_target > accel_step) ? o_out_freq - accel_step : ramp_target;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_gate_enable  <= 1'b0;
      o_searching    <= 1'b0;
      o_vf_scale     <= NORMAL_VF;
      o_local_active <= 1'b0;
    end else begin
      o_gate_enable  <= mode == MD_RUN || mode == MD_SEARCH;
      o_searching    <= mode == MD_SEARCH;
      o_vf_scale     <= (mode == MD_SEARCH) ? search_vf_ratio : NORMAL_VF;
      o_local_active <= local_mode;
    end
  end

  assign tmr_limit = 16'(o_timer_out ? off_delay_setting : on_delay_setting) * SETTING_STEP_TICKS;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tmr_cnt     <= 16'h0;
      o_timer_out <= 1'b0;
    end else if (i_contacts.timer_in == o_timer_out) begin
      tmr_cnt <= 16'h0;
    end else if (tmr_cnt >= tmr_limit) begin
      o_timer_out <= i_contacts.timer_in;
      tmr_cnt     <= 16'h0;
    end else if (tick) begin
      tmr_cnt <= tmr_cnt + 16'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      blink_cnt     <= 10'h0;
      blink_phase   <= 1'b0;
      o_block_blink <= 1'b0;
    end else begin
      if (tick) begin
        blink_cnt <= (blink_cnt == BLINK_TICKS - 10'h1) ? 10'h0 : blink_cnt + 10'h1;
        if (blink_cnt == BLINK_TICKS - 10'h1) begin
          blink_phase <= !blink_phase;
        end
      end
      o_block_blink <= ext_blk && !blink_phase;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_block_to_search;
    mode == MD_BLOCK && next_mode == MD_SEARCH && srch_from_max;
  endsequence

  sequence s_search_relief;
    mode == MD_SEARCH && !ext_blk_eff && !i_power_loss && !srch_edge && run_cmd
      && i_out_current < search_current_level;
  endsequence

  source_defer_a: assert property (mode != MD_STOP |=> local_mode == $past(local_mode))
    else $error("control source changed while drive not stopped");
  gate_block_a: assert property (mode == MD_BLOCK |=> !o_gate_enable)
    else $error("output gate on during block");
  block_delay_a: assert property ($rose(mode == MD_BLOCK) && !$past(i_power_loss) && !$past(srch_edge)
                                  |-> $past(blk_cnt) == BLOCK_DELAY_TICKS)
    else $error("block entered before delay elapsed");
  zero_ref_a: assert property (force_zero |=> o_freq_ref == 16'h0)
    else $error("reference not zero after standstill block");
  blink_idle_a: assert property (!ext_blk |=> !o_block_blink)
    else $error("block indication without block");
  min_block_a: assert property (mode == MD_BLOCK && next_mode != MD_BLOCK |-> mb_cnt >= mb_limit)
    else $error("block left before minimum time");
  search_max_a: assert property (s_block_to_search |=> o_out_freq == $past(fmax))
    else $error("search did not start at maximum");
  search_end_a: assert property (s_search_relief |=> mode == MD_RUN ##1 !o_searching)
    else $error("search not ended on low current");
  search_vf_a: assert property (mode == MD_SEARCH |=> o_vf_scale == $past(search_vf_ratio))
    else $error("search ratio not applied");
  timer_delay_a: assert property ($changed(o_timer_out) |-> $past(tmr_cnt) >= $past(tmr_limit))
    else $error("timer output changed early");
  hold_freeze_a: assert property (mode == MD_RUN && next_mode == MD_RUN && hold_eff
                                  |=> o_out_freq == $past(o_out_freq))
    else $error("speed moved during hold");

endmodule

/* verif/mis_contact_model.sv */
`timescale 1ns/1ps
module mis_contact_model (
  input  wire logic              i_sys_clk,
  output mis_pkg::mis_contacts_s o_contacts,
  output logic [15:0]            o_analog_ref,
  output logic [7:0]             o_out_current,
  output logic                   o_power_loss
);
  import mis_pkg::*;
  initial begin
    o_contacts = '0;
    o_contacts.block_nc = 1'b1;
    o_analog_ref = 16'h0;
    o_out_current = 8'h0;
    o_power_loss = 1'b0;
  end
  // switches move just after an edge, held until the next call
  task automatic drive(input mis_contacts_s c, input logic [15:0] a, input logic [7:0] cur, input logic pl);
    mis_contacts_s k;
    k = c;
    // never both search functions at once
    if (k.search_max) k.search_set = 1'b0;
    @(posedge i_sys_clk);
    o_contacts <= k; // three preset inputs plus jog, timer on input only
    o_analog_ref <= a;
    o_out_current <= cur;
    o_power_loss <= pl;
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import mis_pkg::*;
  localparam int TK = 4;
  logic          i_sys_clk = 1'b0;
  logic          i_reset_n = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [7:0]    paddr = 8'h00;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, rd;
  logic          pready, pslverr, er, ge, tmo, blk, loc, srch, plw;
  logic [15:0]   fref, ofreq, ar;
  logic [15:0]   ana = 16'h0;
  logic [7:0]    vf, oc;
  logic [7:0]    cur = 8'h0;
  logic          pl = 1'b0;
  mis_contacts_s c, ct;
  int            n_mismatch = 0;
  int            n_checks = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  mis_contact_model pm (.i_sys_clk(i_sys_clk), .o_contacts(ct), .o_analog_ref(ar), .o_out_current(oc),
    .o_power_loss(plw));
  mis_top #(.TICK_CYCLES(TK)) uut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .i_contacts(ct), .i_analog_ref(ar), .i_out_current(oc), .i_power_loss(plw),
    .o_gate_enable(ge), .o_freq_ref(fref), .o_out_freq(ofreq), .o_vf_scale(vf), .o_timer_out(tmo),
    .o_block_blink(blk), .o_local_active(loc), .o_searching(srch));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  task automatic put;
    pm.drive(c, ana, cur, pl);
  endtask

  // blink phase runs free, so wait for the wanted level instead of assuming it
  task automatic wblk(input logic v);
    int k;
    k = 0;
    while (blk !== v && k < 2100) begin
      @(posedge i_sys_clk);
      k++;
    end
  endtask

  task automatic wsrch;
    int k;
    k = 0;
    while (srch !== 1'b1 && k < 900) begin
      @(posedge i_sys_clk);
      k++;
    end
  endtask

  // request held until pready is seen at an edge, released only after it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) n_mismatch++;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    c = '0;
    c.block_nc = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    apb(1'b0, OFS_FMAX, 32'h0);
    chk("fmax", rd, 32'h258);
    apb(1'b0, OFS_SRCH_CUR, 32'h0);
    chk("scur", rd, 32'h6e);
    apb(1'b1, OFS_SRCH_CUR, 32'hc9);
    apb(1'b0, OFS_SRCH_CUR, 32'h0);
    chk("scur_max", rd, 32'hc8);
    apb(1'b1, OFS_SRCH_VF, 32'h96);
    apb(1'b0, OFS_SRCH_VF, 32'h0);
    chk("svf_max", rd, 32'h64);
    apb(1'b0, 8'h38, 32'h0);
    chk("jog", rd, 32'h3c);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    apb(1'b1, OFS_SRCH_VF, 32'h32);
    // back to the default level, so 150% keeps a search going
    apb(1'b1, OFS_SRCH_CUR, 32'h6e);
    apb(1'b1, OFS_MIN_BLOCK, 32'h1);
    apb(1'b1, OFS_ON_DELAY, 32'h1);
    apb(1'b1, OFS_ACCEL_STEP, 32'hfff);
    for (int i = 0; i < 6; i++) apb(1'b1, OFS_PRESET0 + 8'(4 * i), 32'(16 * (i + 1)));
    $display("regs done");
    ana = 16'h123;
    for (int i = 0; i < 6; i++) begin
      c.preset_sel = 4'(i);
      put;
      cyc(4);
      chk("preset", 32'(fref), (i == 0) ? 32'h123 : 32'(16 * (i + 1)));
    end
    c.preset_sel = 4'hd;
    put;
    cyc(4);
    chk("jog_sel", 32'(fref), 32'h3c);
    c.preset_sel = 4'h0;
    c.local_sel = 1'b1;
    put;
    cyc(4);
    chk("local", 32'(loc), 32'h1);
    chk("p1_local", 32'(fref), 32'h10);
    c.local_sel = 1'b0;
    c.fwd_run = 1'b1;
    put;
    cyc(8);
    chk("run_remote", 32'(ge), 32'h1);
    c.local_sel = 1'b1;
    put;
    cyc(8);
    chk("defer", 32'(loc), 32'h0);
    c.fwd_run = 1'b0;
    put;
    cyc(20);
    chk("switched", 32'(loc), 32'h1);
    c.key_fwd = 1'b1;
    put;
    cyc(8);
    chk("run_key", 32'(ge), 32'h1);
    c.key_fwd = 1'b0;
    c.local_sel = 1'b0;
    put;
    cyc(20);
    $display("source done");
    c.preset_sel = 4'h1;
    c.block_no = 1'b1;
    put;
    cyc(60);
    chk("blk_early", 32'(fref), 32'h20);
    cyc(40);
    chk("blk_zero", 32'(fref), 32'h0);
    wblk(1'b1);
    chk("blink", 32'(blk), 32'h1);
    wblk(1'b0);
    chk("blink_off", 32'(blk), 32'h0);
    c.block_no = 1'b0;
    put;
    cyc(500);
    chk("stay_stop", 32'(ge), 32'h0);
    c.fwd_run = 1'b1;
    cur = 8'd150;
    put;
    cyc(20);
    c.block_no = 1'b1;
    put;
    cyc(60);
    chk("run_early", 32'(ge), 32'h1);
    cyc(40);
    chk("coast", 32'(ge), 32'h0);
    chk("ref_kept", 32'(fref), 32'h20);
    c.block_no = 1'b0;
    put;
    wsrch;
    chk("recover", 32'(srch), 32'h1);
    chk("vf_srch", 32'(vf), 32'h32);
    cur = 8'd0;
    put;
    cyc(4);
    chk("srch_end", 32'(srch), 32'h0);
    chk("vf_norm", 32'(vf), 32'h64);
    $display("block done");
    c.search_max = 1'b1;
    put;
    cyc(4);
    chk("srch_blk", 32'(ge), 32'h0);
    c.search_max = 1'b0;
    cur = 8'd150;
    put;
    wsrch;
    chk("from_max", 32'(ofreq > 16'd590), 32'h1);
    cyc(400);
    chk("srch_decel", 32'(ofreq < 16'd590), 32'h1);
    cur = 8'd0;
    put;
    cyc(4);
    pl = 1'b1;
    put;
    cyc(500);
    chk("loss_off", 32'(ge), 32'h0);
    pl = 1'b0;
    cur = 8'd150;
    put;
    cyc(4);
    chk("loss_srch", 32'(srch), 32'h1);
    cur = 8'd0;
    put;
    cyc(4);
    $display("search done");
    c.timer_in = 1'b1;
    put;
    cyc(300);
    chk("on_early", 32'(tmo), 32'h0);
    cyc(150);
    chk("on", 32'(tmo), 32'h1);
    c.timer_in = 1'b0;
    put;
    cyc(4);
    chk("off", 32'(tmo), 32'h0);
    c.hold = 1'b1;
    put;
    cyc(2);
    c.preset_sel = 4'h2;
    put;
    cyc(40);
    chk("hold", 32'(ofreq), 32'h20);
    c.hold = 1'b0;
    put;
    cyc(12);
    chk("resume", 32'(ofreq), 32'h30);
    c.hold = 1'b1;
    c.fwd_run = 1'b0;
    put;
    cyc(20);
    chk("hold_stop", 32'(ofreq), 32'h0);
    chk("hold_gate", 32'(ge), 32'h0);
    c.hold = 1'b0;
    apb(1'b1, OFS_CTRL, 32'h2);
    c.preset_sel = 4'h0;
    c.sample_hold = 1'b1;
    ana = 16'h155;
    put;
    cyc(300);
    chk("sh_early", 32'(fref), 32'h0);
    cyc(150);
    chk("sh_track", 32'(fref), 32'h155);
    c.sample_hold = 1'b0;
    ana = 16'h1aa;
    put;
    cyc(8);
    chk("sh_freeze", 32'(fref), 32'h155);
    $display("hold and sample done");
    apb(1'b1, OFS_CTRL, 32'h1);
    c.block_nc = 1'b0;
    c.rev_run = 1'b1;
    put;
    cyc(100);
    chk("nc_block", 32'(ge), 32'h0);
    wblk(1'b1);
    chk("nc_blink", 32'(blk), 32'h1);
    wblk(1'b0);
    chk("nc_blink_off", 32'(blk), 32'h0);
    $display("timer and nc done");
    tally_and_finish;
  end
endmodule
